// ---- design/cis_consts.vh ----
`ifndef CIS_CONSTS_VH
`define CIS_CONSTS_VH

// ----------------------------------------------------------------
// wishbone register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CIS_ADDR_W 8
`define CIS_OFS_WORK 8'h00
`define CIS_OFS_STATUS 8'h04
`define CIS_OFS_CTRL 8'h08
`define CIS_OFS_STATE 8'h0C

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define CIS_ST_CARRY 0
`define CIS_ST_DIGIT 1
`define CIS_ST_ZERO 2
`define CIS_ST_PDOWN 3
`define CIS_ST_TOUT 4

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define CIS_CT_GIE 0
`define CIS_CT_RUN 1
`define CIS_CT_WAKE 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIS_RST_WORK 8'h00
`define CIS_RST_TOUT 1'b1
`define CIS_RST_PDOWN 1'b1
`define CIS_RST_GIE 1'b0
`define CIS_RST_RUN 1'b1

// ----------------------------------------------------------------
// instruction word layout and opcode patterns
// ----------------------------------------------------------------
`define CIS_IW 14
`define CIS_DEST_BIT 7
`define CIS_MASK_LIT4 14'h3C00
`define CIS_MASK_SUB 14'h3E00
`define CIS_MASK_STORE 14'h3F80
`define CIS_MASK_ROT 14'h3F00
`define CIS_MASK_FULL 14'h3FFF
`define CIS_OP_LOAD_LIT 14'h3000
`define CIS_OP_RET_LIT 14'h3400
`define CIS_OP_LIT_SUB 14'h3C00
`define CIS_OP_STORE_W 14'h0080
`define CIS_OP_ROT_LEFT 14'h0D00
`define CIS_OP_ROT_RIGHT 14'h0C00
`define CIS_OP_IRQ_RET 14'h0009
`define CIS_OP_RETURN 14'h0008
`define CIS_OP_SLEEP 14'h0063

`endif

// ---- design/cis_exec.v ----
// Overview of operation
// RQ1: load literal writes the 8-bit literal into working register, flags unchanged.
// RQ2: interrupt return loads program counter from stack top, sets interrupt enable.
// RQ3: store copies working register into addressed file register, flags untouched.
// RQ4: return with literal loads working register and pops stack into program counter.
// RQ5: subroutine return pops stack into program counter, two cycles, no flags.
// RQ6: rotate left through carry: old carry to bit 0, bit 7 to carry.
// RQ7: rotate right through carry: old carry to bit 7, bit 0 to carry.
// RQ8: rotate destination bit 0 selects working register, 1 the file register.
// RQ9: sleep clears the watchdog counter and its prescaler.
// RQ10: sleep sets the time-out flag and clears the power-down flag.
// RQ11: after sleep the core halts with the main oscillator stopped.
// RQ12: literal subtract puts literal minus working register into it, updates flags.
// RQ13: subtract carry means no borrow, digit carry no nibble borrow, zero on zero.
// RQ14: all three returns take two cycles and flush the fetched instruction.
`timescale 1ns/1ps
`include "cis_consts.vh"

module cis_exec (
  input wire clk,
  input wire reset,
  // instruction from fetch
  input wire instr_valid,
  input wire [13:0] instr,
  output reg instr_ready,
  // register file
  output reg [6:0] file_addr,
  input wire [7:0] file_rd_data,
  output reg file_wr_en,
  output reg [7:0] file_wr_data,
  // stack and program counter
  input wire [12:0] stack_top,
  output reg stack_pop,
  output reg pc_load,
  output reg [12:0] program_counter,
  output reg flush,
  // watchdog and power
  output reg watchdog_clear,
  output reg prescaler_clear,
  output reg sleep_active,
  output reg osc_halt,
  input wire wake_req,
  output reg global_irq_enable,
  output reg timeout_flag,
  output reg powerdown_flag,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_FLUSH = 2'd2;
  localparam ST_SLEEP = 2'd3;

  // ----------------------------------------------------------------
  // architectural state and flags
  // ----------------------------------------------------------------
  reg [1:0] state;
  reg [13:0] op;
  reg [7:0] work;
  reg carry;
  reg digit_carry_flag;
  reg zero;
  reg run_enable;

  // operand fields and datapath taps
  wire [7:0] lit;
  wire dest_file;
  wire [7:0] sub_diff;
  wire sub_c;
  wire sub_dc;
  wire sub_z;
  wire bus_write;
  wire bus_hit;
  wire wake_write;

  assign lit = op[7:0];
  assign dest_file = op[`CIS_DEST_BIT];

  // ----------------------------------------------------------------
  // subtract datapath
  // ----------------------------------------------------------------
  // carry comes from the ninth difference bit, set means no borrow
  cis_sub8 u_sub (
    .minuend(lit),
    .subtrahend(work),
    .diff(sub_diff),
    .no_borrow(sub_c),
    .nibble_no_borrow(sub_dc),
    .is_zero(sub_z)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------

  // opcode match helpers
  wire is_load_lit = (op & `CIS_MASK_LIT4) == `CIS_OP_LOAD_LIT;
  wire is_ret_lit = (op & `CIS_MASK_LIT4) == `CIS_OP_RET_LIT;
  wire is_lit_sub = (op & `CIS_MASK_SUB) == `CIS_OP_LIT_SUB;
  wire is_store = (op & `CIS_MASK_STORE) == `CIS_OP_STORE_W;
  wire is_rot_left = (op & `CIS_MASK_ROT) == `CIS_OP_ROT_LEFT;
  wire is_rot_right = (op & `CIS_MASK_ROT) == `CIS_OP_ROT_RIGHT;
  wire is_irq_ret = (op & `CIS_MASK_FULL) == `CIS_OP_IRQ_RET;
  wire is_return = (op & `CIS_MASK_FULL) == `CIS_OP_RETURN;
  wire is_sleep = (op & `CIS_MASK_FULL) == `CIS_OP_SLEEP;

  // only carry moves on a rotate; digit carry and zero keep their values
  // rotate results, file data is valid since address went out at accept
  wire [7:0] rot_left_val = {file_rd_data[6:0], carry};
  wire [7:0] rot_right_val = {carry, file_rd_data[7:1]};

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  // map: 00h working register, 04h status (power-down, time-out read only),
  // 08h control (interrupt enable, run, wake), 0Ch sequencer state;
  // sel[0] alone qualifies writes since every field sits in the low byte;
  // wake is a write-one pulse, never stored, so it always reads back as 0
  // write lands on the edge where ack is seen high, as the master expects
  assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wake_write = bus_write & (wb_adr_i == `CIS_OFS_CTRL) & wb_dat_i[`CIS_CT_WAKE];

  // ack one cycle after the request, read data captured alongside
  always @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_hit;
      if (bus_hit) begin
        case (wb_adr_i)
          `CIS_OFS_WORK: wb_dat_o <= {24'h000000, work};
          `CIS_OFS_STATUS: wb_dat_o <= {27'h0000000, timeout_flag, powerdown_flag,
                                        zero, digit_carry_flag, carry};
          `CIS_OFS_CTRL: wb_dat_o <= {30'h00000000, run_enable, global_irq_enable};
          `CIS_OFS_STATE: wb_dat_o <= {28'h0000000, osc_halt, sleep_active, state};
          default: wb_dat_o <= 32'h00000000; // unmapped reads as zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer and execution
  // ----------------------------------------------------------------
  // an executing instruction wins over a software write to the same state
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      op <= 14'h0000;
      instr_ready <= 1'b0;
      file_addr <= 7'h00;
      file_wr_en <= 1'b0;
      file_wr_data <= 8'h00;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      program_counter <= 13'h0000;
      flush <= 1'b0;
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;
      sleep_active <= 1'b0;
      osc_halt <= 1'b0;
      global_irq_enable <= `CIS_RST_GIE;
      timeout_flag <= `CIS_RST_TOUT;
      powerdown_flag <= `CIS_RST_PDOWN;
      work <= `CIS_RST_WORK;
      carry <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero <= 1'b0;
      run_enable <= `CIS_RST_RUN;
    end else begin
      // strobes are single cycle unless set below
      file_wr_en <= 1'b0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      flush <= 1'b0;
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;

      // software side writes, only while no instruction is in execution
      if (bus_write && state != ST_EXEC) begin
        case (wb_adr_i)
          `CIS_OFS_WORK: work <= wb_dat_i[7:0];
          `CIS_OFS_STATUS: begin
            carry <= wb_dat_i[`CIS_ST_CARRY];
            digit_carry_flag <= wb_dat_i[`CIS_ST_DIGIT];
            zero <= wb_dat_i[`CIS_ST_ZERO];
          end
          `CIS_OFS_CTRL: begin
            global_irq_enable <= wb_dat_i[`CIS_CT_GIE];
            run_enable <= wb_dat_i[`CIS_CT_RUN];
          end
          default: ;
        endcase
      end

      case (state)
        ST_IDLE: begin
          // the run bit gates acceptance, letting software freeze the core
          // file address goes out at accept, so read data is ready in exec
          instr_ready <= run_enable;
          if (instr_valid && instr_ready) begin
            op <= instr;
            file_addr <= instr[6:0];
            instr_ready <= 1'b0;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          instr_ready <= run_enable;
          if (is_load_lit) begin
            // RQ1: literal into work
            work <= lit;
          end else if (is_lit_sub) begin
            // RQ12: literal minus work
            work <= sub_diff;
            // RQ13: borrow style flags
            carry <= sub_c;
            digit_carry_flag <= sub_dc;
            zero <= sub_z;
          end else if (is_store) begin
            // RQ3: work to file
            file_wr_en <= 1'b1;
            file_wr_data <= work;
          end else if (is_rot_left || is_rot_right) begin
            // RQ6: left through carry
            // RQ7: right through carry
            carry <= is_rot_left ? file_rd_data[7] : file_rd_data[0];
            // RQ8: destination select
            if (dest_file) begin
              file_wr_en <= 1'b1;
              file_wr_data <= is_rot_left ? rot_left_val : rot_right_val;
            end else begin
              work <= is_rot_left ? rot_left_val : rot_right_val;
            end
          end else if (is_irq_ret || is_ret_lit || is_return) begin
            // RQ5: pop into counter
            stack_pop <= 1'b1;
            pc_load <= 1'b1;
            program_counter <= stack_top;
            // RQ14: second cycle flushes
            flush <= 1'b1;
            instr_ready <= 1'b0;
            state <= ST_FLUSH;
            // RQ4: literal with return
            if (is_ret_lit) begin
              work <= lit;
            end
            // RQ2: enable interrupts
            if (is_irq_ret) begin
              global_irq_enable <= 1'b1;
            end
          end else if (is_sleep) begin
            // RQ9: clear watchdog
            watchdog_clear <= 1'b1;
            prescaler_clear <= 1'b1;
            // RQ10: power flags
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
            // RQ11: halt oscillator
            sleep_active <= 1'b1;
            osc_halt <= 1'b1;
            instr_ready <= 1'b0;
            state <= ST_SLEEP;
          end
          // anything else outside the subset retires as a no-op
        end
        ST_FLUSH: begin
          // the already fetched word is dropped here
          instr_ready <= run_enable;
          state <= ST_IDLE;
        end
        ST_SLEEP: begin
          // RQ11: stay halted until woken
          instr_ready <= 1'b0;
          if (wake_req || wake_write) begin
            sleep_active <= 1'b0;
            osc_halt <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // cis_exec

// ---- design/cis_sub8.v ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// literal minus working register, with flags
// ----------------------------------------------------------------
module cis_sub8 (
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  output wire [7:0] diff,
  output wire no_borrow,
  output wire nibble_no_borrow,
  output wire is_zero
);

  wire [8:0] full;
  wire [4:0] low;

  // ninth bit set means a borrow was taken
  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = full[7:0];
  assign no_borrow = ~full[8];
  assign nibble_no_borrow = ~low[4];
  assign is_zero = (full[7:0] == 8'h00);

endmodule // cis_sub8

// ---- testbench/cis_exec_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the execution core
// ----------------------------------------
module cis_exec_checker (
  input wire clk,
  input wire reset,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire instr_ready,
  input wire [6:0] file_addr,
  input wire file_wr_en,
  input wire [12:0] stack_top,
  input wire stack_pop,
  input wire pc_load,
  input wire [12:0] program_counter,
  input wire flush,
  input wire watchdog_clear,
  input wire prescaler_clear,
  input wire sleep_active,
  input wire osc_halt,
  input wire global_irq_enable,
  input wire timeout_flag,
  input wire powerdown_flag,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o
);
  // decode of the word taken at this edge
  wire acc = instr_valid && instr_ready;
  wire is_irq = acc && instr == 14'h0009;
  wire is_ret = is_irq || acc && (instr == 14'h0008 || (instr & 14'h3C00) == 14'h3400);
  wire is_slp = acc && instr == 14'h0063;
  wire is_st = acc && (instr & 14'h3F80) == 14'h0080;
  wire is_rot = acc && (instr & 14'h3E00) == 14'h0C00;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // a return strobes once, then stays busy through the flush cycle
  sequence ret_strobes;
    pc_load && stack_pop && flush;
  endsequence
  sequence ret_busy;
    !instr_ready [*2] ##1 instr_ready;
  endsequence
  a_ret_strobes: assert property (is_ret |-> ##2 ret_strobes)
    else $error("return strobes missing");
  a_ret_busy: assert property (is_ret |=> ret_busy)
    else $error("return not two cycles");
  a_ret_target: assert property (is_ret |-> ##2 program_counter == $past(stack_top))
    else $error("wrong return address");
  a_irq_enable: assert property (is_irq |-> ##2 global_irq_enable)
    else $error("irq enable not set");
  a_sleep_clear: assert property (is_slp |-> ##2 watchdog_clear && prescaler_clear)
    else $error("watchdog not cleared");
  a_sleep_flags: assert property (is_slp |-> ##2 timeout_flag && !powerdown_flag)
    else $error("sleep flags wrong");
  a_osc_halted: assert property (osc_halt == sleep_active)
    else $error("oscillator halt mismatch");
  a_sleep_halt: assert property (is_slp |-> ##2 osc_halt && sleep_active && !instr_ready)
    else $error("sleep did not halt core");
  a_store_write: assert property (is_st |-> ##2 file_wr_en)
    else $error("store did not write");
  a_rot_dest: assert property (is_rot |-> ##2 file_wr_en == $past(instr[7], 2))
    else $error("rotate destination wrong");
  a_file_addr: assert property ((is_st || is_rot) |=> file_addr == $past(instr[6:0]))
    else $error("file address wrong");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus not answered");
endmodule // cis_exec_checker

bind cis_exec cis_exec_checker chk_u (.*);

// ---- testbench/cis_exec_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench for the execution core
// ----------------------------------------
module cis_exec_tb;
  wire instr_ready, file_wr_en, stack_pop, pc_load, flush, watchdog_clear, prescaler_clear;
  wire sleep_active, osc_halt, global_irq_enable, timeout_flag, powerdown_flag, wb_ack_o;
  wire [6:0] file_addr;
  wire [7:0] file_wr_data;
  wire [12:0] program_counter;
  wire [31:0] wb_dat_o;
  reg clk = 0, reset = 1, instr_valid = 0, wake_req = 0, wb_cyc_i = 0, wb_stb_i = 0;
  reg wb_we_i = 0, c, d, nc;
  reg [13:0] instr = 0;
  reg [12:0] stack_top = 0;
  reg [7:0] wb_adr_i = 0, k, w, v, r;
  reg [6:0] f;
  reg [3:0] wb_sel_i = 0;
  reg [31:0] wb_dat_i = 0, q;
  reg [7:0] mem [0:127];
  integer errors = 0, samples_checked = 0, i, n;
  wire [7:0] file_rd_data = mem[file_addr];

  cis_exec dut_u (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .file_addr(file_addr), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .stack_top(stack_top),
    .stack_pop(stack_pop), .pc_load(pc_load), .program_counter(program_counter),
    .flush(flush), .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
    .sleep_active(sleep_active), .osc_halt(osc_halt), .wake_req(wake_req),
    .global_irq_enable(global_irq_enable), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  // clock and file register model
  always #50 clk = ~clk;
  always @(posedge clk) if (file_wr_en) mem[file_addr] <= file_wr_data;

  task chk(input string nm, input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0s exp %h got %h", nm, exp, got);
    end
  endtask

  // one classic bus cycle, held until ack is sampled
  task wb(input we, input [7:0] a, input [31:0] dat);
    @(posedge clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1) errors = errors + 1;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task rd(input [7:0] a, input [31:0] e, input string nm);
    wb(0, a, 0);
    chk(nm, q, e);
  endtask

  task issue(input [13:0] wd);
    @(posedge clk);
    instr_valid <= 1;
    instr <= wd;
    do @(posedge clk); while (instr_ready !== 1'b1);
    instr_valid <= 0;
  endtask

  task idle;
    n = 0;
    do begin @(posedge clk); n = n + 1; end while (instr_ready !== 1'b1 && n < 30);
    if (instr_ready !== 1'b1) errors = errors + 1;
  endtask

  // extra edge lets the file write land before it is read back
  task exec(input [13:0] wd);
    issue(wd);
    idle;
    @(posedge clk);
  endtask

  task complete_run;
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #5000000;
    errors = errors + 1;
    complete_run;
  end

  initial begin
    n = $urandom(32'h74987be7);
    for (i = 0; i < 128; i = i + 1) mem[i] = $urandom;
    repeat (16) @(posedge clk);
    reset <= 0;
    rd(8'h08, 32'h02, "ctrl");
    rd(8'h10, 32'h00, "unmapped");
    // literal load keeps flags; subtract with borrow corners
    for (i = 0; i < 12; i = i + 1) begin
      w = (i == 0) ? 8'h01 : (i == 2) ? 8'h01 : $urandom;
      k = (i == 0) ? 8'h00 : (i == 1) ? w : (i == 2) ? 8'h10 : $urandom;
      r = k - w;
      wb(1, 8'h04, 32'h07);
      exec({6'h30, w});
      rd(8'h00, w, "work");
      rd(8'h04, 32'h1F, "keep");
      exec({6'h3C, k});
      rd(8'h00, r, "diff");
      rd(8'h04, {27'h3, r == 0, k[3:0] >= w[3:0], k >= w}, "subflags");
    end
    // store to edge and random addresses
    for (i = 0; i < 6; i = i + 1) begin
      w = $urandom;
      f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : $urandom;
      exec({6'h30, w});
      exec({7'h01, f});
      chk("store", mem[f], w);
    end
    // rotate both ways, both carries, both destinations
    for (i = 0; i < 16; i = i + 1) begin
      c = i[0];
      d = i[1];
      f = $urandom;
      v = $urandom;
      w = $urandom;
      mem[f] <= v;
      wb(1, 8'h00, w);
      wb(1, 8'h04, c);
      exec({5'b00110, ~i[2], d, f});
      r = i[2] ? {c, v[7:1]} : {v[6:0], c};
      nc = i[2] ? v[0] : v[7];
      rd(8'h00, d ? w : r, "rotw");
      chk("rotf", mem[f], d ? r : v);
      rd(8'h04, {27'h0, 2'h3, 2'h0, nc}, "rotc");
    end
    // the three returns
    wb(1, 8'h08, 32'h02);
    for (i = 0; i < 3; i = i + 1) begin
      stack_top <= $urandom;
      k = $urandom;
      exec(i == 0 ? 14'h0008 : i == 1 ? {6'h34, k} : 14'h0009);
      chk("pc", program_counter, stack_top);
      if (i == 1) rd(8'h00, k, "retlit");
    end
    chk("gie", global_irq_enable, 1);
    // sleep, woken by pin then by register
    for (i = 0; i < 2; i = i + 1) begin
      issue(14'h0063);
      repeat (3) @(posedge clk);
      chk("sleep", {sleep_active, osc_halt, timeout_flag, powerdown_flag}, 4'hE);
      rd(8'h0C, 32'h0F, "state");
      if (i) wb(1, 8'h08, 32'h06);
      else wake_req <= 1;
      idle;
      wake_req <= 0;
      chk("wake", sleep_active, 0);
    end
    wb(0, 8'h04, 0);
    chk("pd", q & 32'h18, 32'h10);
    // run enable off refuses instructions
    wb(1, 8'h08, 32'h00);
    repeat (2) @(posedge clk);
    chk("run", instr_ready, 0);
    wb(1, 8'h08, 32'h02);
    complete_run;
  end
endmodule // cis_exec_tb
